// >>> ifc_pkg.sv
// Shared constants, carrier structs and states for the instruction fetch cache
// Notes on behaviour
// - Cache is direct-mapped, 16-byte lines, capacity 0, 1, 2, 4, 8 or 16 KB.
// - The fetch queue ahead of the decoder holds sixteen instruction bytes.
// - Queue takes up to eight bytes from cache, four from bus interface unit.
// - Up to seven bytes are offered to decode; decode removes what it consumed.
// - Fill data arrive four bytes wide, so a line comes as four words.
// - A lookup miss requests the whole containing line from the bus interface unit.
// - A hit delivers its bytes to the queue in one cycle, no wait states.
// - Empty queue with a miss pending raises stall to decode until data arrive.
// - Any cache line can be invalidated so rewritten code is refetched.
// - Big-endian alignment: lowest byte address is the most significant byte.
// - Fetched bytes stay queued until decode consumes them or a redirect clears the queue.
// - Low-power mode switches the cache arrays off under power management control.
// - Cache-enable clear makes every fetch a miss; fills requested while it is clear never enter the cache.
// - Fill words from the one holding the fetch address onward are forwarded to the queue before the line fill finishes.
// - Indexed flush clears the addressed line's valid bit without a tag compare.
// - A fill error marks the queued bytes faulty and the line is not cached.
package ifc_pkg;
    localparam int ADDR_W = 32;
    localparam int OFF_W = 4;
    localparam int LINE_BYTES = 16;
    localparam int WORD_BYTES = 4;
    localparam int QUEUE_BYTES = 16;
    localparam int CACHE_PUSH = 8;
    localparam int DECODE_BYTES = 7;
    localparam int LINES_PER_KB = 1024 / LINE_BYTES;
    localparam logic [4:0] HIT_ROOM = 5'h08;
    localparam logic [4:0] BUS_ROOM = 5'h0C;
    localparam logic [2:0] WCNT_FULL = 3'h4;
    localparam logic [3:0] PUSH_CACHE = 4'h8;
    localparam logic [3:0] PUSH_WORD = 4'h4;
    localparam logic [31:0] RESET_PC = 32'h0000_0000;

    typedef struct packed {
        logic vld;
        logic flt;
        logic [7:0] data;
    } ifc_qent_t;

    typedef struct packed {
        logic valid;
        logic cacheable;
        logic [ADDR_W-1:0] addr;
    } ifc_fill_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [0:WORD_BYTES-1][7:0] data;
    } ifc_fill_rsp_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] target;
    } ifc_redirect_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } ifc_flush_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_FILL = 2'b10
    } ifc_state_t;
endpackage : ifc_pkg

// >>> ifc_fetch_queue.sv
// Sixteen-byte shifting fetch queue between cache and decode
`timescale 1ns/1ps
`default_nettype none
module ifc_fetch_queue (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic [2:0] pop_n,
    input wire logic [3:0] push_n,
    input wire logic [ifc_pkg::CACHE_PUSH-1:0][7:0] push_data,
    input wire logic push_flt,
    output var ifc_pkg::ifc_qent_t [ifc_pkg::QUEUE_BYTES-1:0] ent_reg,
    output logic [4:0] count_reg
);
    import ifc_pkg::*;

    ifc_qent_t ent_next [QUEUE_BYTES];
    logic [4:0] count_next;
    logic [4:0] pop_c;
    logic [4:0] rem;

    // Pop is clamped so a bad decode count cannot underflow the queue
    always_comb
    begin
        pop_c = ({2'b00, pop_n} > count_reg) ? count_reg : {2'b00, pop_n};
        rem = count_reg - pop_c;
        count_next = clear ? 5'h00 : rem + {1'b0, push_n};
    end

    // Survivors slide to the head, new bytes land right behind them
    generate
        for (genvar i = 0; i < QUEUE_BYTES; i++)
        begin : g_ent
            logic [4:0] src;
            logic [4:0] k;
            always_comb
            begin
                src = 5'(i) + pop_c;
                k = 5'(i) - rem;
                ent_next[i] = '0;
                if (clear)
                begin
                    ent_next[i] = '0;
                end
                else if (5'(i) < rem)
                begin
                    ent_next[i] = ent_reg[src[3:0]];
                end
                else if (k < {1'b0, push_n})
                begin
                    ent_next[i].vld = 1'b1;
                    ent_next[i].flt = push_flt;
                    ent_next[i].data = push_data[k[2:0]];
                end
            end
        end
    endgenerate

    // Storage; all entries are flops so the decode window is registered
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ent_reg <= '0;
            count_reg <= 5'h00;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < QUEUE_BYTES; i++)
            begin
                ent_reg[i] <= ent_next[i];
            end
            count_reg <= count_next;
        end
    end
endmodule : ifc_fetch_queue
`default_nettype wire

// >>> ifc_fetch_unit.sv
// Instruction fetch unit: direct-mapped cache, miss fill and fetch queue
`timescale 1ns/1ps
`default_nettype none
module ifc_fetch_unit #(
    parameter int CACHE_KB = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cache_enable,
    input wire logic power_down,
    input wire ifc_pkg::ifc_redirect_t redirect,
    input wire ifc_pkg::ifc_flush_t indexed_line_flush_request,
    input wire logic [2:0] consume_n,
    output var ifc_pkg::ifc_qent_t [ifc_pkg::DECODE_BYTES-1:0] decode_window,
    output logic decode_stall,
    output var ifc_pkg::ifc_fill_req_t fill_req,
    input wire ifc_pkg::ifc_fill_rsp_t fill_rsp
);
    import ifc_pkg::*;

    // Array geometry; a zero-size build keeps one dummy line that is never used
    localparam int LINES = (CACHE_KB == 0) ? 1 : CACHE_KB * LINES_PER_KB;
    localparam int IDX_W = (LINES > 1) ? $clog2(LINES) : 1;
    localparam int TAG_W = ADDR_W - OFF_W - IDX_W;
    localparam int LADDR_W = ADDR_W - OFF_W;
    localparam bit CACHE_ON = (CACHE_KB != 0);

    // Cache arrays; only the valid bits need a reset value
    logic [0:LINE_BYTES-1][7:0] data_mem [LINES];
    logic [TAG_W-1:0] tag_mem [LINES];
    logic [LINES-1:0] valid_reg;
    logic [LINES-1:0] valid_next;

    // Fetch and fill state
    ifc_state_t state_reg;
    ifc_state_t state_next;
    logic [ADDR_W-1:0] pc_reg;
    logic [ADDR_W-1:0] pc_next;
    logic [LADDR_W-1:0] fill_line_reg;
    logic [LADDR_W-1:0] fill_line_next;
    logic fill_cache_reg;
    logic fill_cache_next;
    logic [WORD_BYTES-1:0] fill_err_reg;
    logic [WORD_BYTES-1:0] fill_err_next;
    logic [2:0] wcnt_reg;
    logic [2:0] wcnt_next;
    logic written_reg;
    logic written_next;
    logic [0:LINE_BYTES-1][7:0] line_reg;
    logic [0:LINE_BYTES-1][7:0] line_next;
    ifc_fill_req_t req_reg;
    ifc_fill_req_t req_next;
    logic stall_reg;
    logic stall_next;

    // Lookup and queue handshake
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] fidx;
    logic [IDX_W-1:0] flush_idx;
    logic [0:LINE_BYTES-1][7:0] rd_line;
    logic [TAG_W-1:0] rd_tag;
    logic lookup_on;
    logic hit;
    logic in_line;
    logic use_line;
    logic mem_we;
    logic q_clear;
    logic [3:0] push_n;
    logic push_flt;
    logic [CACHE_PUSH-1:0][7:0] push_data;
    logic [0:LINE_BYTES-1][7:0] src_line;
    ifc_qent_t [QUEUE_BYTES-1:0] q_ent;
    logic [4:0] q_count;
    logic [4:0] q_pop;
    logic [4:0] q_after;

    // Tag lookup; with zero capacity or disabled cache no lookup happens at all
    always_comb
    begin
        // Zero-size build pins every index to its single dummy line
        idx = (LINES > 1) ? pc_reg[OFF_W +: IDX_W] : '0;
        fidx = (LINES > 1) ? fill_line_reg[IDX_W-1:0] : '0;
        flush_idx = (LINES > 1) ? indexed_line_flush_request.addr[OFF_W +: IDX_W] : '0;
        rd_line = data_mem[idx];
        rd_tag = tag_mem[idx];
        lookup_on = CACHE_ON && cache_enable && !power_down;
        hit = lookup_on && valid_reg[idx] && (rd_tag == pc_reg[ADDR_W-1 -: TAG_W]);
        in_line = (pc_reg[ADDR_W-1:OFF_W] == fill_line_reg);
    end

    // Aligner: byte at pc goes first, line element 0 is the top byte
    always_comb
    begin
        src_line = use_line ? line_reg : rd_line;
        for (int k = 0; k < CACHE_PUSH; k++)
        begin
            push_data[k] = src_line[pc_reg[3:0] + 4'(k)];
        end
    end

    // Fetch sequencing, fill capture, line write and invalidation
    always_comb
    begin
        state_next = state_reg;
        pc_next = pc_reg;
        fill_line_next = fill_line_reg;
        fill_cache_next = fill_cache_reg;
        fill_err_next = fill_err_reg;
        wcnt_next = wcnt_reg;
        written_next = written_reg;
        line_next = line_reg;
        valid_next = valid_reg;
        req_next = '0;
        push_n = 4'h0;
        push_flt = 1'b0;
        use_line = 1'b0;
        mem_we = 1'b0;
        q_clear = 1'b0;

        // Words are always absorbed, so the bus side never waits on the queue
        if (state_reg == ST_FILL && fill_rsp.valid && wcnt_reg != WCNT_FULL)
        begin
            for (int j = 0; j < WORD_BYTES; j++)
            begin
                line_next[{wcnt_reg[1:0], 2'(j)}] = fill_rsp.data[j];
            end
            fill_err_next[wcnt_reg[1:0]] = fill_rsp.err;
            wcnt_next = wcnt_reg + 3'h1;
        end

        unique case (state_reg)
            ST_RUN:
            begin
                if (redirect.valid)
                begin
                    q_clear = 1'b1;
                    pc_next = redirect.target;
                end
                else if (power_down)
                begin
                    pc_next = pc_reg;   // Arrays off, fetch waits
                end
                else if (hit)
                begin
                    if (q_count <= HIT_ROOM)
                    begin
                        push_n = PUSH_CACHE - {1'b0, pc_reg[2:0]};
                        pc_next = pc_reg + {28'h0000000, push_n};
                    end
                end
                else
                begin
                    req_next.valid = 1'b1;
                    req_next.cacheable = lookup_on;
                    req_next.addr = {pc_reg[ADDR_W-1:OFF_W], 4'h0};
                    fill_line_next = pc_reg[ADDR_W-1:OFF_W];
                    fill_cache_next = lookup_on;
                    fill_err_next = '0;
                    wcnt_next = 3'h0;
                    written_next = 1'b0;
                    state_next = ST_FILL;
                end
            end
            ST_FILL:
            begin
                if (redirect.valid)
                begin
                    q_clear = 1'b1;
                    pc_next = redirect.target;
                end
                else if (in_line && wcnt_reg > {1'b0, pc_reg[3:2]} && q_count <= BUS_ROOM)
                begin
                    use_line = 1'b1;
                    push_n = PUSH_WORD - {2'b00, pc_reg[1:0]};
                    push_flt = fill_err_reg[pc_reg[3:2]];
                    pc_next = pc_reg + {28'h0000000, push_n};
                end
                if (wcnt_reg == WCNT_FULL && !written_reg)
                begin
                    written_next = 1'b1;
                    mem_we = CACHE_ON && fill_cache_reg && (fill_err_reg == '0)
                        && !power_down;
                end
                // Leave once the line is complete and fetch has moved off it
                if (wcnt_reg == WCNT_FULL && written_reg && !in_line)
                begin
                    state_next = ST_RUN;
                end
                if (wcnt_reg == WCNT_FULL && written_reg && redirect.valid)
                begin
                    state_next = ST_RUN;
                end
            end
        endcase

        if (mem_we)
        begin
            valid_next[fidx] = 1'b1;
        end
        // Flush after the fill write, so a flush of the same index wins
        if (CACHE_ON && indexed_line_flush_request.valid)
        begin
            valid_next[flush_idx] = 1'b0;
        end
    end

    // Stall follows the queue's next occupancy so it drops with the first byte
    always_comb
    begin
        q_pop = ({2'b00, consume_n} > q_count) ? q_count : {2'b00, consume_n};
        q_after = q_clear ? 5'h00 : q_count - q_pop + {1'b0, push_n};
        stall_next = (state_next == ST_FILL) && (q_after == 5'h00);
    end

    // Control registers
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_RUN;
            pc_reg <= RESET_PC;
            fill_line_reg <= '0;
            fill_cache_reg <= 1'b0;
            fill_err_reg <= '0;
            wcnt_reg <= 3'h0;
            written_reg <= 1'b0;
            line_reg <= '0;
            valid_reg <= '0;
            req_reg <= '0;
            stall_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            fill_line_reg <= fill_line_next;
            fill_cache_reg <= fill_cache_next;
            fill_err_reg <= fill_err_next;
            wcnt_reg <= wcnt_next;
            written_reg <= written_next;
            line_reg <= line_next;
            valid_reg <= valid_next;
            req_reg <= req_next;
            stall_reg <= stall_next;
        end
    end

    // Array write port; no reset, contents are guarded by the valid bits
    always_ff @(posedge mclk)
    begin
        if (clk_en && mem_we)
        begin
            data_mem[fidx] <= line_reg;
            tag_mem[fidx] <= fill_line_reg[LADDR_W-1 -: TAG_W];
        end
    end

    // Queue holds bytes until decode pops them or a redirect clears it
    ifc_fetch_queue u_queue (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .clear(q_clear),
        .pop_n(consume_n),
        .push_n(push_n),
        .push_data(push_data),
        .push_flt(push_flt),
        .ent_reg(q_ent),
        .count_reg(q_count)
    );

    // Outputs straight from flops
    assign decode_window = q_ent[DECODE_BYTES-1:0];
    assign decode_stall = stall_reg;
    assign fill_req = req_reg;
endmodule : ifc_fetch_unit
`default_nettype wire

// >>> ifc_mem_model.sv
// Bus interface unit stand-in answering line fills word by word
`timescale 1ns/1ps
`default_nettype none
module ifc_mem_model (
    input wire logic mclk,
    input wire ifc_pkg::ifc_fill_req_t fill_req,
    input wire logic [3:0] gap,
    input wire logic err_en,
    output var ifc_pkg::ifc_fill_rsp_t fill_rsp
);
    import ifc_pkg::*;
    logic [31:0] a;
    logic e;
    // One fill at a time; each byte carries the low byte of its own address; one process drives the bus
    initial
    begin
        fill_rsp = '0;
        forever
        begin
            @(negedge mclk);
            if (fill_req.valid === 1'b1)
            begin
                a = fill_req.addr;
                e = err_en; // Latched so a late change cannot split a line
                repeat (gap) @(negedge mclk);
                for (int w = 0; w < LINE_BYTES / WORD_BYTES; w++)
                begin
                    fill_rsp.valid = 1'b1;
                    fill_rsp.err = e;
                    for (int b = 0; b < WORD_BYTES; b++)
                        fill_rsp.data[b] = a[7:0] + 8'(4 * w + b);
                    @(negedge mclk);
                end
                fill_rsp.valid = 1'b0;
                fill_rsp.err = 1'b0;
                fill_rsp.data = ~fill_rsp.data; // Released bus shows no stale word
            end
        end
    end
endmodule : ifc_mem_model
`default_nettype wire

// >>> ifc_checker.sv
// Port-level assertions for the fetch unit
`timescale 1ns/1ps
`default_nettype none
module ifc_checker #(
    parameter int CACHE_KB = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cache_enable,
    input wire logic power_down,
    input wire ifc_pkg::ifc_redirect_t redirect,
    input wire ifc_pkg::ifc_flush_t indexed_line_flush_request,
    input wire logic [2:0] consume_n,
    input wire ifc_pkg::ifc_qent_t [ifc_pkg::DECODE_BYTES-1:0] decode_window,
    input wire logic decode_stall,
    input wire ifc_pkg::ifc_fill_req_t fill_req,
    input wire ifc_pkg::ifc_fill_rsp_t fill_rsp
);
    import ifc_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // No further request, for any line, may come in the four cycles after a request
    req_gap_a: assert property (fill_req.valid |=> !fill_req.valid [*4])
        else $error("fill request repeated too soon");
    req_align_a: assert property (fill_req.valid |-> fill_req.addr[3:0] == 4'h0)
        else $error("fill request not line aligned");
    nocache_req_a: assert property (fill_req.valid && (CACHE_KB == 0 ||
        !$past(cache_enable)) |-> !fill_req.cacheable)
        else $error("uncached fetch requested as cacheable");
    clear_q_a: assert property (clk_en && redirect.valid |=> !decode_window[0].vld)
        else $error("queue not emptied by redirect");
    stall_empty_a: assert property (decode_stall |-> !decode_window[0].vld)
        else $error("stall raised with bytes queued");
    win_prefix_a: assert property (decode_window[1].vld |-> decode_window[0].vld)
        else $error("gap in decode window");
    hold_q_a: assert property (clk_en && consume_n == 3'h0 && !redirect.valid &&
        decode_window[0].vld |=> decode_window[0] == $past(decode_window[0]))
        else $error("queued byte lost without consume");
    pop_q_a: assert property (clk_en && consume_n == 3'h1 && !redirect.valid &&
        decode_window[1].vld |=> decode_window[0] == $past(decode_window[1]))
        else $error("single byte consume misaligned");
    // Main scenarios reached
    cover property (fill_req.valid && !fill_req.cacheable);
    cover property (decode_stall);
    cover property (decode_window[0].flt);
    cover property (!clk_en && decode_window[0].vld);
endmodule : ifc_checker
bind ifc_fetch_unit ifc_checker #(.CACHE_KB(CACHE_KB)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .cache_enable(cache_enable),
    .power_down(power_down), .redirect(redirect),
    .indexed_line_flush_request(indexed_line_flush_request), .consume_n(consume_n),
    .decode_window(decode_window), .decode_stall(decode_stall),
    .fill_req(fill_req), .fill_rsp(fill_rsp));
`default_nettype wire

// >>> test_instruction_fetch_cache.sv
// Self-checking bench for the fetch unit with a fill model
`timescale 1ns/1ps
`default_nettype none
module test_instruction_fetch_cache;
    import ifc_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic cache_enable = 1'b1;
    logic power_down = 1'b0;
    logic clk_en = 1'b1;
    logic err_en = 1'b0;
    logic [3:0] gap = 4'h3;
    logic [2:0] consume_n = 3'h0;
    ifc_redirect_t redirect = '0;
    ifc_flush_t flush = '0;
    ifc_qent_t [DECODE_BYTES-1:0] win;
    logic stall;
    ifc_fill_req_t req;
    ifc_fill_rsp_t rsp;
    int errors = 0;
    int checks = 0;
    // Core clock, 10 ns
    always #5 mclk = ~mclk;
    ifc_fetch_unit #(.CACHE_KB(16)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .cache_enable(cache_enable),
        .power_down(power_down), .redirect(redirect),
        .indexed_line_flush_request(flush), .consume_n(consume_n),
        .decode_window(win), .decode_stall(stall), .fill_req(req), .fill_rsp(rsp));
    ifc_mem_model u_mem (.mclk(mclk), .fill_req(req), .gap(gap), .err_en(err_en),
        .fill_rsp(rsp));
    task automatic stop_test;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [71:0] seen, input logic [71:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    task automatic bound_out(input int i);
        if (i == 60)
        begin
            errors++;
            stop_test();
        end
    endtask : bound_out
    // Waits for a request to one line, skipping requests to other lines
    task automatic wait_req(input logic [31:0] a);
        int i;
        for (i = 0; i < 60 && !(req.valid === 1'b1 && req.addr === a); i++)
            @(negedge mclk);
        bound_out(i);
    endtask : wait_req
    task automatic wait_on(input int k);
        int i;
        for (i = 0; i < 60 && win[k].vld !== 1'b1; i++)
            @(negedge mclk);
        bound_out(i);
    endtask : wait_on
    task automatic jump(input logic [31:0] t);
        redirect = {1'b1, t};
        @(negedge mclk);
        redirect = '0;
    endtask : jump
    task automatic check_win(input logic [7:0] b, input logic f);
        for (int i = 0; i < DECODE_BYTES; i++)
            cmp(72'(win[i]), 72'({1'b1, f, b + 8'(i)}));
    endtask : check_win
    // Cold miss, slow fill, forwarding and one-byte consume
    task automatic s_miss;
        wait_req(32'h0);
        cmp(72'({req.cacheable, stall}), 72'h3);
        wait_on(0);
        cmp(72'({win[4].vld, win[3].vld, stall}), 72'h2);
        wait_on(6);
        check_win(8'h00, 1'b0);
        consume_n = 3'h1;
        @(negedge mclk);
        consume_n = 3'h0;
        cmp(72'(win[0].data), 72'h01);
        repeat (30) @(negedge mclk);
        check_win(8'h01, 1'b0);
        gap = 4'h0;
    endtask : s_miss
    // Redirect back into a cached line
    task automatic s_hit;
        jump(32'h0);
        cmp(72'(win[0].vld), 72'h0);
        repeat (2) @(negedge mclk);
        check_win(8'h00, 1'b0);
    endtask : s_hit
    // Flush by index with a foreign tag, then refetch
    task automatic s_flush;
        flush = {1'b1, 32'h0000_4000};
        @(negedge mclk);
        flush = '0;
        jump(32'h0);
        wait_req(32'h0);
        cmp(72'(req.cacheable), 72'h1);
        wait_on(6);
        check_win(8'h00, 1'b0);
    endtask : s_flush
    // Cache off: both fetches go out uncached
    task automatic s_nocache;
        cache_enable = 1'b0;
        for (int n = 0; n < 2; n++)
        begin
            // Each jump to 0x40 misses and sends a new uncached request for the line
            repeat (6) @(negedge mclk);
            jump(32'h40);
            wait_req(32'h40);
            cmp(72'(req.cacheable), 72'h0);
            wait_on(6);
            check_win(8'h40, 1'b0);
        end
        cache_enable = 1'b1;
    endtask : s_nocache
    // Faulty fill marks bytes and leaves the line uncached
    task automatic s_error;
        err_en = 1'b1;
        jump(32'h80);
        wait_req(32'h80);
        wait_on(6);
        check_win(8'h80, 1'b1);
        err_en = 1'b0;
        // Let the faulty fill end so the refetch must come from memory
        repeat (6) @(negedge mclk);
        jump(32'h80);
        wait_req(32'h80);
        wait_on(6);
        check_win(8'h80, 1'b0);
    endtask : s_error
    // Arrays off hold fetch until power returns
    task automatic s_power;
        power_down = 1'b1;
        jump(32'h0);
        repeat (4) @(negedge mclk);
        cmp(72'(win[0].vld), 72'h0);
        power_down = 1'b0;
        wait_on(6);
        check_win(8'h00, 1'b0);
    endtask : s_power
    // Clock enable low freezes queue and fetch despite a consume
    task automatic s_freeze;
        clk_en = 1'b0;
        consume_n = 3'h3;
        repeat (3) @(negedge mclk);
        check_win(8'h00, 1'b0);
        clk_en = 1'b1;
        @(negedge mclk);
        consume_n = 3'h0;
        check_win(8'h03, 1'b0);
    endtask : s_freeze
    // Main sequence: reset values, then each scenario
    initial
    begin
        repeat (2) @(negedge mclk);
        cmp(72'(win), 72'h0);
        cmp(72'({stall, req.valid}), 72'h0);
        sys_rst = 1'b0;
        s_miss();
        s_hit();
        s_flush();
        s_nocache();
        s_error();
        s_power();
        s_freeze();
        stop_test();
    end
endmodule : test_instruction_fetch_cache
`default_nettype wire
